/* File: verilog/ccu_pkg.sv */
package ccu_pkg;

  // register map, one byte per address
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_VAL_LO = 4'h1;
  localparam logic [3:0] ADDR_VAL_HI = 4'h2;
  localparam logic [3:0] ADDR_TB_SEL = 4'h3;
  localparam logic [3:0] ADDR_TB_SRC = 4'h4;
  localparam logic [3:0] ADDR_TB_ON = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  localparam logic [3:0] ADDR_CNT_BASE = 4'h8;

  localparam int unsigned NUM_TB = 3;
  localparam int unsigned TB_W = 16;
  localparam logic [3:0] CNT_SPAN = 4'h6;

  // unit_mode_field codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOG = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI = 4'hA;
  localparam logic [3:0] MODE_CMP_SEV = 4'hB;
  localparam logic [1:0] MODE_CAP_GRP = 2'h1;

  // timebase clock sources
  localparam logic [1:0] SRC_SYS = 2'h0;
  localparam logic [1:0] SRC_INSTR = 2'h1;
  localparam logic [1:0] SRC_SOSC = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // field layout
  localparam int unsigned CTRL_IMPL_W = 6;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned DUTY_LSB = 4;

  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [5:0] TB_SRC_RST = 6'h00;
  localparam logic [2:0] TB_ON_RST = 3'h0;
  localparam logic [1:0] TB_SEL_RST = 2'h0;
  localparam logic [15:0] VAL_RST = 16'h0000;

  // timing
  localparam int unsigned INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;

endpackage : ccu_pkg

/* File: verilog/ccu_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Contract
// - each timebase counts from system clock, clock/4, secondary oscillator or external pin.
// - timebases on system or instruction clock hold while asleep.
// - a held timebase resumes from its held value on wake, never reloaded.
// - capture keeps working in sleep when the timebase runs from an external source.
// - the unit picks one of three 16-bit timebases through the timebase select register.
// - in compare mode the value pair is matched against the count at every count update.
// - on a match the mode field chooses toggle, set, clear, special event or interrupt only.
// - the match event flag is set in the same cycle the pin action is taken.
// - every compare mode raises the interrupt through the flag and its enable.
// - unimplemented control bits, such as the bridge output field, read zero.
// - capture events are falling, rising, the 4th rising edge and every 16th after it, or every 16th rising edge.
// - a capture copies the 16-bit count into the value pair and sets the flag.
// - a later capture overwrites an unread captured value.
// - the edge prescaler clears on reset, when off and whenever not capturing.
module ccu_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic sleep_mode,
  input wire logic unit_pin_in,
  input wire logic sosc_in,
  input wire logic ext_clk_in,
  output logic unit_pin_out,
  output logic unit_pin_oe_n,
  output logic special_event,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] pin_sync_r;
  logic [1:0] sosc_sync_r;
  logic [1:0] ext_sync_r;
  logic pin_d_r;
  logic sosc_d_r;
  logic ext_d_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_r <= 2'h0;
      sosc_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      pin_d_r <= 1'b0;
      sosc_d_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], unit_pin_in};
      sosc_sync_r <= {sosc_sync_r[0], sosc_in};
      ext_sync_r <= {ext_sync_r[0], ext_clk_in};
      pin_d_r <= pin_sync_r[1];
      sosc_d_r <= sosc_sync_r[1];
      ext_d_r <= ext_sync_r[1];
    end
  end

  wire pin_rise = pin_sync_r[1] & ~pin_d_r;
  wire pin_fall = ~pin_sync_r[1] & pin_d_r;
  wire sosc_rise = sosc_sync_r[1] & ~sosc_d_r;
  wire ext_rise = ext_sync_r[1] & ~ext_d_r;

  //////////////////////////////////////////////////////////////////////////
  // software registers
  logic [5:0] ctl_r;
  logic [15:0] val_r;
  logic [1:0] tb_sel_r;
  logic [5:0] tb_src_r;
  logic [2:0] tb_on_r;
  logic flag_r;
  logic mask_r;

  wire wr_ctl = wr_en & (addr == ccu_pkg::ADDR_CTRL);
  wire wr_lo = wr_en & (addr == ccu_pkg::ADDR_VAL_LO);
  wire wr_hi = wr_en & (addr == ccu_pkg::ADDR_VAL_HI);
  wire wr_sel = wr_en & (addr == ccu_pkg::ADDR_TB_SEL);
  wire wr_src = wr_en & (addr == ccu_pkg::ADDR_TB_SRC);
  wire wr_on = wr_en & (addr == ccu_pkg::ADDR_TB_ON);
  wire wr_mask = wr_en & (addr == ccu_pkg::ADDR_MASK);
  wire rd_status = rd_en & (addr == ccu_pkg::ADDR_STATUS);

  wire [3:0] mode = ctl_r[ccu_pkg::MODE_LSB +: 4];
  wire is_off = (mode == ccu_pkg::MODE_OFF);
  wire is_cap = (mode[3:2] == ccu_pkg::MODE_CAP_GRP);
  wire is_pin_cmp = (mode == ccu_pkg::MODE_CMP_TOG) | (mode == ccu_pkg::MODE_CMP_SET)
                  | (mode == ccu_pkg::MODE_CMP_CLR);
  wire is_cmp = is_pin_cmp | (mode == ccu_pkg::MODE_CMP_SWI)
              | (mode == ccu_pkg::MODE_CMP_SEV);

  //////////////////////////////////////////////////////////////////////////
  // timebases
  logic [1:0] div_r;
  logic [15:0] cnt_r [ccu_pkg::NUM_TB];
  logic [2:0] sev_pend_r;
  logic [2:0] tick;
  logic [2:0] sev_set;

  wire [1:0] div_nxt = sleep_mode ? div_r : div_r + 2'h1;
  wire instr_tick = ~sleep_mode & (div_r == ccu_pkg::INSTR_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < ccu_pkg::NUM_TB; g++) begin : g_tb
      wire [1:0] src = tb_src_r[2*g +: 2];
      wire src_tick = (src == ccu_pkg::SRC_SYS) ? ~sleep_mode :
                      (src == ccu_pkg::SRC_INSTR) ? instr_tick :
                      (src == ccu_pkg::SRC_SOSC) ? sosc_rise : ext_rise;
      assign tick[g] = tb_on_r[g] & src_tick;
      wire pend_nxt = (sev_pend_r[g] & ~tick[g]) | sev_set[g];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_r[g] <= 16'h0000;
          sev_pend_r[g] <= 1'b0;
        end else begin
          // held value simply stays, so counting resumes from it
          if (tick[g]) begin
            cnt_r[g] <= sev_pend_r[g] ? 16'h0000 : cnt_r[g] + 16'h0001;
          end
          sev_pend_r[g] <= pend_nxt;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // timebase selection
  wire [1:0] tb_idx = (tb_sel_r == 2'h3) ? 2'h0 : tb_sel_r;
  wire [15:0] sel_cnt = cnt_r[tb_idx];
  wire sel_tick = tick[tb_idx];
  logic upd_r;

  //////////////////////////////////////////////////////////////////////////
  // capture
  logic [3:0] pre_r;

  wire pre_last4 = (pre_r == ccu_pkg::PRE4_LAST);
  wire pre_last16 = (pre_r == ccu_pkg::PRE16_LAST);
  wire [3:0] pre_nxt = !is_cap ? 4'h0 :
                       pin_rise ? pre_r + 4'h1 : pre_r;
  wire cap_evt = (mode == ccu_pkg::MODE_CAP_FALL) ? pin_fall :
                 (mode == ccu_pkg::MODE_CAP_RISE) ? pin_rise :
                 (mode == ccu_pkg::MODE_CAP_4) ? pin_rise & pre_last4 :
                 (mode == ccu_pkg::MODE_CAP_16) ? pin_rise & pre_last16 : 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= 4'h0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare
  wire match = is_cmp & upd_r & (sel_cnt == val_r);
  wire sev_match = match & (mode == ccu_pkg::MODE_CMP_SEV);
  assign sev_set = {2'h0, sev_match} << tb_idx;

  logic pin_r;
  logic sev_r;

  wire pin_nxt = is_off ? 1'b0 :
                 !match ? pin_r :
                 (mode == ccu_pkg::MODE_CMP_TOG) ? ~pin_r :
                 (mode == ccu_pkg::MODE_CMP_SET) ? 1'b1 :
                 (mode == ccu_pkg::MODE_CMP_CLR) ? 1'b0 : pin_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_r <= 1'b0;
      pin_r <= 1'b0;
      sev_r <= 1'b0;
    end else begin
      upd_r <= sel_tick;
      pin_r <= pin_nxt;
      sev_r <= sev_match;
    end
  end

  assign unit_pin_out = pin_r;
  assign unit_pin_oe_n = ~is_pin_cmp;
  assign special_event = sev_r;

  //////////////////////////////////////////////////////////////////////////
  // value pair, flag, configuration
  wire set_evt = cap_evt | match;
  wire flag_nxt = set_evt | (flag_r & ~rd_status);
  wire [15:0] val_wr = {wr_hi ? wr_data : val_r[15:8], wr_lo ? wr_data : val_r[7:0]};
  wire [15:0] val_nxt = cap_evt ? sel_cnt : val_wr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= ccu_pkg::CTRL_RST;
      val_r <= ccu_pkg::VAL_RST;
      tb_sel_r <= ccu_pkg::TB_SEL_RST;
      tb_src_r <= ccu_pkg::TB_SRC_RST;
      tb_on_r <= ccu_pkg::TB_ON_RST;
      flag_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      if (wr_ctl) ctl_r <= wr_data[5:0];
      if (wr_sel) tb_sel_r <= wr_data[1:0];
      if (wr_src) tb_src_r <= wr_data[5:0];
      if (wr_on) tb_on_r <= wr_data[2:0];
      if (wr_mask) mask_r <= wr_data[0];
      val_r <= val_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign irq = flag_r & mask_r;

  //////////////////////////////////////////////////////////////////////////
  // read path
  wire [3:0] cnt_off = addr - ccu_pkg::ADDR_CNT_BASE;
  wire cnt_hit = (addr >= ccu_pkg::ADDR_CNT_BASE) & (cnt_off < ccu_pkg::CNT_SPAN);
  wire [1:0] cnt_idx = cnt_hit ? cnt_off[2:1] : 2'h0;
  wire [15:0] cnt_rd = cnt_r[cnt_idx];
  wire [7:0] cnt_byte = cnt_off[0] ? cnt_rd[15:8] : cnt_rd[7:0];

  wire [7:0] rd_mux =
    (addr == ccu_pkg::ADDR_CTRL) ? {2'h0, ctl_r} :
    (addr == ccu_pkg::ADDR_VAL_LO) ? val_r[7:0] :
    (addr == ccu_pkg::ADDR_VAL_HI) ? val_r[15:8] :
    (addr == ccu_pkg::ADDR_TB_SEL) ? {6'h00, tb_sel_r} :
    (addr == ccu_pkg::ADDR_TB_SRC) ? {2'h0, tb_src_r} :
    (addr == ccu_pkg::ADDR_TB_ON) ? {5'h00, tb_on_r} :
    (addr == ccu_pkg::ADDR_STATUS) ? {7'h00, flag_r} :
    (addr == ccu_pkg::ADDR_MASK) ? {7'h00, mask_r} :
    cnt_hit ? cnt_byte : 8'h00;

  logic [7:0] rd_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= rd_en ? rd_mux : 8'h00;
    end
  end

  assign rd_data = rd_r;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire [1:0] src0 = tb_src_r[1:0];

  property p_sleep_hold;
    (sleep_mode && (src0 == ccu_pkg::SRC_SYS || src0 == ccu_pkg::SRC_INSTR)) |=>
      cnt_r[0] == $past(cnt_r[0]);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("timebase moved in sleep");

  property p_resume;
    (!sleep_mode && tb_on_r[0] && src0 == ccu_pkg::SRC_SYS && !sev_pend_r[0]) |=>
      cnt_r[0] == $past(cnt_r[0]) + 16'h0001;
  endproperty
  a_resume: assert property (p_resume) else $error("timebase did not step by one");

  property p_instr_rate;
    (tb_on_r[0] && src0 == ccu_pkg::SRC_INSTR && !sleep_mode && !sev_pend_r[0]
      && div_r == ccu_pkg::INSTR_LAST) |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001
      ##1 cnt_r[0] == $past(cnt_r[0]) [*3];
  endproperty
  a_instr_rate: assert property (p_instr_rate) else $error("instruction rate wrong");

  property p_cap_sleep;
    (sleep_mode && cap_evt) |=> flag_r;
  endproperty
  a_cap_sleep: assert property (p_cap_sleep) else $error("capture lost in sleep");

  property p_capture;
    cap_evt |=> (val_r == $past(sel_cnt)) && flag_r;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_set_same;
    (match && mode == ccu_pkg::MODE_CMP_SET) |=> unit_pin_out && flag_r;
  endproperty
  a_set_same: assert property (p_set_same) else $error("set action or flag late");

  property p_toggle;
    (match && mode == ccu_pkg::MODE_CMP_TOG) |=> unit_pin_out != $past(unit_pin_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_match_irq;
    (match && mask_r && !wr_mask) |=> irq;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match raised no irq");

  property p_ctl_zero;
    (rd_en && addr == ccu_pkg::ADDR_CTRL) |=> rd_data[7:6] == 2'h0;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("bridge bits not zero");

  property p_pre_clear;
    !is_cap |=> pre_r == 4'h0;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

  property p_every4;
    (mode == ccu_pkg::MODE_CAP_4 && pin_rise && pre_r != ccu_pkg::PRE4_LAST) |-> !cap_evt;
  endproperty
  a_every4: assert property (p_every4) else $error("early 4th-edge capture");

  property p_swi_nopin;
    (mode == ccu_pkg::MODE_CMP_SWI) |-> unit_pin_oe_n;
  endproperty
  a_swi_nopin: assert property (p_swi_nopin) else $error("pin driven in irq mode");

  c_capture: cover property (cap_evt ##1 flag_r);
  c_toggle: cover property (match && mode == ccu_pkg::MODE_CMP_TOG);
  c_sev: cover property (sev_match ##[1:20] cnt_r[tb_idx] == 16'h0000);

endmodule : ccu_top

/* File: dv/ccu_pin_model.sv */
module ccu_pin_model (
  input wire logic clk,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe_n,
  input wire logic ext_run,
  output logic unit_pin_in,
  output logic sosc_in,
  output logic ext_clk_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lvl = 1'b0;
  logic [2:0] div = 3'h0;
  // wire level: the unit wins while its enable is low
  assign unit_pin_in = unit_pin_oe_n ? lvl : unit_pin_out;
  initial begin
    sosc_in = 1'b0;
    ext_clk_in = 1'b0;
  end
  // oscillator free running, external clock still unless enabled
  always @(posedge clk) begin
    div <= div + 3'h1;
    if (div == 3'h7) sosc_in <= ~sosc_in;
    if (ext_run && div[0]) ext_clk_in <= ~ext_clk_in;
  end
  // n edges of the given sense, each level held long enough for the sync stages
  task automatic edges(input logic rise, input int n);
    repeat (n) begin
      @(posedge clk);
      lvl <= ~rise;
      repeat (4) @(posedge clk);
      lvl <= rise;
      repeat (4) @(posedge clk);
    end
  endtask : edges
endmodule : ccu_pin_model

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sleep_mode = 1'b0;
  logic ext_run = 1'b0;
  logic [7:0] rd_data;
  logic unit_pin_in, sosc_in, ext_clk_in, unit_pin_out, unit_pin_oe_n, special_event, irq;
  int fail_count = 0;
  int total_checks = 0;
  logic [15:0] cnt, cap;
  logic [7:0] a, b;
  always #2.5 clk = ~clk;
  ccu_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .sleep_mode(sleep_mode), .unit_pin_in(unit_pin_in),
    .sosc_in(sosc_in), .ext_clk_in(ext_clk_in), .unit_pin_out(unit_pin_out),
    .unit_pin_oe_n(unit_pin_oe_n), .special_event(special_event), .irq(irq));
  ccu_pin_model u_pin (.clk(clk), .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
    .ext_run(ext_run), .unit_pin_in(unit_pin_in), .sosc_in(sosc_in), .ext_clk_in(ext_clk_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd
  task automatic rdchk(input logic [3:0] ad, input logic [7:0] e);
    rd(ad, b);
    chk({8'h00, b}, {8'h00, e});
  endtask : rdchk
  task automatic rd16(input logic [3:0] ad, output logic [15:0] v);
    logic [7:0] lo, hi;
    rd(ad, lo);
    rd(ad + 4'h1, hi);
    v = {hi, lo};
  endtask : rd16
  // match on timebase 2, then look at pin, enable and trigger in the flag's cycle
  task automatic cmp(input logic [3:0] mode, input logic pin, input logic sev);
    logic [15:0] v;
    logic oe;
    oe = !(mode inside {ccu_pkg::MODE_CMP_TOG, ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_CLR});
    wr(ccu_pkg::ADDR_TB_ON, 8'h00);
    rd16(ccu_pkg::ADDR_CNT_BASE + 4'h4, cnt);
    v = cnt + 16'h0110;
    wr(ccu_pkg::ADDR_VAL_LO, v[7:0]);
    wr(ccu_pkg::ADDR_VAL_HI, v[15:8]);
    wr(ccu_pkg::ADDR_CTRL, {4'h0, mode});
    rd(ccu_pkg::ADDR_STATUS, b);
    wr(ccu_pkg::ADDR_TB_ON, 8'h04);
    repeat (300) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) break;
    end
    chk(irq, 1'b1);
    chk(unit_pin_out, pin);
    chk(special_event, sev);
    chk(unit_pin_oe_n, oe);
  endtask : cmp
  // capture after n_pre silent edges, value pair must hold exp
  task automatic capt(input logic [3:0] mode, input logic rise, input int n_pre,
                      input logic [15:0] exp);
    logic [15:0] v;
    wr(ccu_pkg::ADDR_CTRL, 8'h00);
    wr(ccu_pkg::ADDR_CTRL, {4'h0, mode});
    rd(ccu_pkg::ADDR_STATUS, b);
    u_pin.edges(rise, n_pre);
    repeat (6) @(posedge clk);
    rdchk(ccu_pkg::ADDR_STATUS, 8'h00);
    u_pin.edges(rise, 1);
    repeat (6) @(posedge clk);
    chk(irq, 1'b1);
    rdchk(ccu_pkg::ADDR_STATUS, 8'h01);
    rd16(ccu_pkg::ADDR_VAL_LO, v);
    chk(v, exp);
  endtask : capt
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdchk(ccu_pkg::ADDR_CTRL, 8'h00);
    rdchk(ccu_pkg::ADDR_STATUS, 8'h00);
    rdchk(ccu_pkg::ADDR_MASK, 8'h00);
    wr(ccu_pkg::ADDR_CTRL, 8'hFF);
    rdchk(ccu_pkg::ADDR_CTRL, 8'h3F);
    wr(4'hE, 8'h5A);
    rdchk(4'hE, 8'h00);
    // compare modes on timebase 2 from the system clock
    wr(ccu_pkg::ADDR_TB_SEL, 8'h02);
    wr(ccu_pkg::ADDR_TB_SRC, 8'h00);
    wr(ccu_pkg::ADDR_MASK, 8'h01);
    cmp(ccu_pkg::MODE_CMP_TOG, 1'b1, 1'b0);
    cmp(ccu_pkg::MODE_CMP_CLR, 1'b0, 1'b0);
    cmp(ccu_pkg::MODE_CMP_SET, 1'b1, 1'b0);
    cmp(ccu_pkg::MODE_CMP_SWI, 1'b1, 1'b0);
    cmp(ccu_pkg::MODE_CMP_SEV, 1'b1, 1'b1);
    wr(ccu_pkg::ADDR_TB_ON, 8'h00);
    rd16(ccu_pkg::ADDR_CNT_BASE + 4'h4, cnt);
    chk(cnt < 16'h0020, 1'b1);
    wr(ccu_pkg::ADDR_MASK, 8'h00);
    #1;
    chk(irq, 1'b0);
    rdchk(ccu_pkg::ADDR_STATUS, 8'h01);
    rdchk(ccu_pkg::ADDR_STATUS, 8'h00);
    wr(ccu_pkg::ADDR_MASK, 8'h01);
    // timebase 1 on the instruction clock holds in sleep
    wr(ccu_pkg::ADDR_TB_SRC, 8'h04);
    wr(ccu_pkg::ADDR_TB_ON, 8'h02);
    repeat (40) @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ccu_pkg::ADDR_CNT_BASE + 4'h2, a);
    repeat (20) @(posedge clk);
    rdchk(ccu_pkg::ADDR_CNT_BASE + 4'h2, a);
    sleep_mode <= 1'b0;
    repeat (20) @(posedge clk);
    rd(ccu_pkg::ADDR_CNT_BASE + 4'h2, b);
    chk(b > a, 1'b1);
    // timebase 0 counts from the external pin, all asleep
    wr(ccu_pkg::ADDR_TB_ON, 8'h00);
    wr(ccu_pkg::ADDR_TB_SRC, 8'h07);
    wr(ccu_pkg::ADDR_TB_SEL, 8'h00);
    sleep_mode <= 1'b1;
    ext_run <= 1'b1;
    wr(ccu_pkg::ADDR_TB_ON, 8'h01);
    repeat (60) @(posedge clk);
    wr(ccu_pkg::ADDR_TB_ON, 8'h00);
    rd16(ccu_pkg::ADDR_CNT_BASE, cnt);
    chk(cnt != 16'h0000, 1'b1);
    // timebase 0 from the secondary oscillator, still asleep
    wr(ccu_pkg::ADDR_TB_SRC, 8'h06);
    wr(ccu_pkg::ADDR_TB_ON, 8'h01);
    repeat (60) @(posedge clk);
    wr(ccu_pkg::ADDR_TB_ON, 8'h00);
    rd16(ccu_pkg::ADDR_CNT_BASE, cap);
    chk(cap != cnt, 1'b1);
    cnt = cap;
    wr(ccu_pkg::ADDR_TB_SRC, 8'h07);
    capt(ccu_pkg::MODE_CAP_FALL, 1'b0, 0, cnt);
    capt(ccu_pkg::MODE_CAP_RISE, 1'b1, 0, cnt);
    capt(ccu_pkg::MODE_CAP_4, 1'b1, 3, cnt);
    capt(ccu_pkg::MODE_CAP_16, 1'b1, 15, cnt);
    wr(ccu_pkg::ADDR_TB_ON, 8'h01);
    repeat (60) @(posedge clk);
    wr(ccu_pkg::ADDR_TB_ON, 8'h00);
    rd16(ccu_pkg::ADDR_CNT_BASE, cap);
    chk(cap != cnt, 1'b1);
    capt(ccu_pkg::MODE_CAP_RISE, 1'b1, 0, cap);
    // prescaler must restart after the unit is switched off
    wr(ccu_pkg::ADDR_CTRL, {4'h0, ccu_pkg::MODE_CAP_4});
    u_pin.edges(1'b1, 2);
    wr(ccu_pkg::ADDR_CTRL, 8'h00);
    wr(ccu_pkg::ADDR_CTRL, {4'h0, ccu_pkg::MODE_CAP_4});
    rd(ccu_pkg::ADDR_STATUS, b);
    u_pin.edges(1'b1, 3);
    repeat (6) @(posedge clk);
    rdchk(ccu_pkg::ADDR_STATUS, 8'h00);
    print_verdict();
  end
endmodule : testbench
